// >>> i2c_flag_defs.vh
// Named constants for the bus flag and status register block
`ifndef I2C_FLAG_DEFS_VH
`define I2C_FLAG_DEFS_VH

// Register byte addresses on the APB side
`define ADDR_FLAG       12'h000
`define ADDR_CTRL       12'h004
`define ADDR_BITOP      12'h008

// Reset values
`define FLAG_RESET      8'h00
`define CTRL_RESET      8'h00
`define PIN_IDLE        1'b1
`define BIT_RESET       1'b0
`define ZERO32          32'h0000_0000

// Flag register field positions
`define BIT_CANCEL      7
`define BIT_BUSY        6
`define BIT_PERMIT      1
`define BIT_RSVDIS      0

// Control register field positions
`define CTRL_ENABLE     0
`define CTRL_START      1

// Bus line slots in the pin filter
`define PIN_SCL         0
`define PIN_SDA         1
`define PIN_COUNT       2

// APB byte lanes used by the register writes
`define LANE_LO         0
`define LANE_HI         1

// Bit-operation register fields: mask in the low byte, values in the next
`define BITOP_MASK      7:0
`define BITOP_VALUE     15:8
`define BYTE_LO         7:0

// Fill patterns
`define MASK_ALL        8'hff
`define MASK_NONE       8'h00
`define RSVD_FLAG       4'h0
`define RSVD_CTRL       6'h00
`define PAD_WORD        24'h00_0000

`endif

// >>> i2c_bus_flag_register.v
// Bus flag and status register of the I2C controller, with APB access and bus-condition detection
//
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "i2c_flag_defs.vh"

module i2c_bus_flag_register (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        ce,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        scl_in,
  input  wire        sda_in,
  output reg         start_go,
  output reg         bus_busy_flag,
  output reg         operation_enable
);

  // Stored state
  reg        start_cancel_flag;
  reg        initial_start_permit;
  reg        reservation_disable;
  reg        start_request;
  reg        start_allowed;

  // Filtered pin levels, one slot per bus line
  wire [`PIN_COUNT-1:0] pin_raw;
  wire [`PIN_COUNT-1:0] pin_lvl;
  wire [`PIN_COUNT-1:0] pin_last;
  wire       scl_f;
  wire       sda_f;
  wire       scl_prev;
  wire       sda_prev;

  // Write decode
  wire       access;
  wire       wr;
  wire       hit_flag;
  wire       hit_ctrl;
  wire       hit_bitop;
  wire       mapped;
  wire       ctrl_wr;
  wire       enable_rise;
  wire       enable_fall;
  wire       start_set;
  wire       start_det;
  wire       stop_det;
  wire       lane_lo_on;
  wire       lane_pair_on;
  wire       go_now;
  wire       cancel_now;
  reg  [7:0] flag_byte;
  reg  [7:0] ctrl_byte;

  reg  [7:0] flag_wmask;
  reg  [7:0] flag_wval;
  reg        next_permit;
  reg        next_rsvdis;
  reg  [31:0] next_rdata;

  // APB transfer completes at the edge where pready is seen high
  assign access    = psel & penable & pready;
  assign wr        = access & pwrite;
  assign hit_flag  = (paddr == `ADDR_FLAG);
  assign hit_ctrl  = (paddr == `ADDR_CTRL);
  assign hit_bitop = (paddr == `ADDR_BITOP);
  assign mapped    = hit_flag | hit_ctrl | hit_bitop;

  // Byte lanes: lane zero carries every register byte, the bit-op word needs both
  assign lane_lo_on   = pstrb[`LANE_LO];
  assign lane_pair_on = pstrb[`LANE_LO] & pstrb[`LANE_HI];

  // Control register events
  assign ctrl_wr     = wr & hit_ctrl & lane_lo_on;
  assign enable_rise = ctrl_wr & pwdata[`CTRL_ENABLE] & ~operation_enable;
  assign enable_fall = ctrl_wr & ~pwdata[`CTRL_ENABLE] & operation_enable;
  // Start requests only count while the controller runs
  assign start_set   = ctrl_wr & pwdata[`CTRL_START] & pwdata[`CTRL_ENABLE] & operation_enable;

  // Bus conditions seen on the filtered levels, only while enabled
  assign start_det = operation_enable & scl_f & scl_prev & sda_prev & ~sda_f;
  assign stop_det  = operation_enable & scl_f & scl_prev & ~sda_prev & sda_f;

  // Pending request decision; a start seen on the bus this cycle means another
  // master has just taken it, so the request must not go out on top of it
  assign go_now     = start_request & start_allowed & ~bus_busy_flag & ~start_det;
  assign cancel_now = start_request & ~go_now & reservation_disable;

  // Read image of the flag register; reserved positions stay zero
  always @* begin
    flag_byte              = `FLAG_RESET;
    flag_byte[`BIT_CANCEL] = start_cancel_flag;
    flag_byte[`BIT_BUSY]   = bus_busy_flag;
    flag_byte[`BIT_PERMIT] = initial_start_permit;
    flag_byte[`BIT_RSVDIS] = reservation_disable;
  end

  // Read image of the control register
  always @* begin
    ctrl_byte               = `CTRL_RESET;
    ctrl_byte[`CTRL_ENABLE] = operation_enable;
    ctrl_byte[`CTRL_START]  = start_request;
  end

  // Whole-byte write or masked bit write into the flag register
  always @* begin
    flag_wmask = `MASK_NONE;
    flag_wval  = `MASK_NONE;
    if (wr && hit_flag && lane_lo_on) begin
      flag_wmask = `MASK_ALL;
      flag_wval  = pwdata[`BYTE_LO];
    end else if (wr && hit_bitop && lane_pair_on) begin
      flag_wmask = pwdata[`BITOP_MASK];
      flag_wval  = pwdata[`BITOP_VALUE];
    end
  end

  // Configuration bits accept writes only while stopped
  always @* begin
    next_permit = initial_start_permit;
    next_rsvdis = reservation_disable;
    if (!operation_enable) begin
      if (flag_wmask[`BIT_PERMIT]) begin
        next_permit = flag_wval[`BIT_PERMIT];
      end
      if (flag_wmask[`BIT_RSVDIS]) begin
        next_rsvdis = flag_wval[`BIT_RSVDIS];
      end
    end
  end

  // Read mux; unmapped words read zero with an error
  always @* begin
    next_rdata = `ZERO32;
    if (hit_flag) begin
      next_rdata = {`PAD_WORD, flag_byte};
    end else if (hit_ctrl) begin
      next_rdata = {`PAD_WORD, ctrl_byte};
    end
  end

  // APB slave: one wait state, so prdata is a flop and settles on the same edge that raises pready
  always @(posedge clk) begin
    if (sys_rst) begin
      pready  <= `BIT_RESET;
      pslverr <= `BIT_RESET;
      prdata  <= `ZERO32;
    end else if (ce) begin
      if (psel && penable && !pready) begin
        pready  <= 1'b1;
        pslverr <= ~mapped;
        prdata  <= next_rdata;
      end else begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
      end
    end
  end

  // Line slots: raw pins in, filtered levels and their one-cycle-old copies out
  assign pin_raw[`PIN_SCL] = scl_in;
  assign pin_raw[`PIN_SDA] = sda_in;
  assign scl_f             = pin_lvl[`PIN_SCL];
  assign sda_f             = pin_lvl[`PIN_SDA];
  assign scl_prev          = pin_last[`PIN_SCL];
  assign sda_prev          = pin_last[`PIN_SDA];

  // Three-stage pin sampling per line; a level counts once stages two and three
  // agree, so a one-cycle glitch on a slow edge never reaches the detectors
  genvar idx;
  generate
    for (idx = 0; idx < `PIN_COUNT; idx = idx + 1) begin : g_line
      reg stage1;
      reg stage2;
      reg stage3;
      reg level;
      reg level_last;
      always @(posedge clk) begin
        if (sys_rst) begin
          stage1     <= `PIN_IDLE;
          stage2     <= `PIN_IDLE;
          stage3     <= `PIN_IDLE;
          level      <= `PIN_IDLE;
          level_last <= `PIN_IDLE;
        end else if (ce) begin
          stage1     <= pin_raw[idx];
          stage2     <= stage1;
          stage3     <= stage2;
          if (stage2 == stage3) begin
            level <= stage3;
          end
          level_last <= level;
        end
      end
      assign pin_lvl[idx]  = level;
      assign pin_last[idx] = level_last;
    end
  endgenerate

  // Configuration and enable bits
  always @(posedge clk) begin
    if (sys_rst) begin
      initial_start_permit <= `BIT_RESET;
      reservation_disable  <= `BIT_RESET;
      operation_enable     <= `BIT_RESET;
    end else if (ce) begin
      initial_start_permit <= next_permit;
      reservation_disable  <= next_rsvdis;
      if (ctrl_wr) begin
        operation_enable <= pwdata[`CTRL_ENABLE];
      end
    end
  end

  // Bus busy: operation stop overrides, otherwise any set beats a stop
  always @(posedge clk) begin
    if (sys_rst) begin
      bus_busy_flag <= `BIT_RESET;
    end else if (ce) begin
      if (enable_fall) begin
        bus_busy_flag <= 1'b0;
      end else begin
        if (stop_det) begin
          bus_busy_flag <= 1'b0;
        end
        if (start_det) begin
          bus_busy_flag <= 1'b1;
        end
        if (enable_rise && !initial_start_permit) begin
          bus_busy_flag <= 1'b1;
        end
      end
    end
  end

  // Start permission after enabling
  always @(posedge clk) begin
    if (sys_rst) begin
      start_allowed <= `BIT_RESET;
    end else if (ce) begin
      if (enable_fall) begin
        start_allowed <= 1'b0;
      end else if (enable_rise) begin
        start_allowed <= initial_start_permit;
      end else if (stop_det) begin
        start_allowed <= 1'b1;
      end
    end
  end

  // Start request handling: go, wait in reservation, or cancel.
  // A request decided here was written at least one cycle earlier, so a fresh
  // write always wins over the decision that would drop the old one.
  always @(posedge clk) begin
    if (sys_rst) begin
      start_request     <= `BIT_RESET;
      start_cancel_flag <= `BIT_RESET;
      start_go          <= `BIT_RESET;
    end else if (ce) begin
      start_go <= 1'b0;
      if (enable_fall) begin
        start_request     <= 1'b0;
        start_cancel_flag <= 1'b0;
      end else begin
        if (go_now) begin
          start_go      <= 1'b1;
          start_request <= 1'b0;
        end else if (cancel_now) begin
          start_request     <= 1'b0;
          start_cancel_flag <= 1'b1;
        end
        if (start_set) begin
          start_request     <= 1'b1;
          start_cancel_flag <= 1'b0;
        end
      end
    end
  end

  // Software writes to bits 7 and 6 are dropped by construction: no write path
  // reaches start_cancel_flag or bus_busy_flag from flag_wval.

endmodule

// >>> i2c_flag_checker.sv
// Port assertions for the bus flag register
`timescale 1ns/1ps
module i2c_flag_checker (
  input logic        clk,
  input logic        sys_rst,
  input logic        ce,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [3:0]  pstrb,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  input logic        scl_in,
  input logic        sda_in,
  input logic        start_go,
  input logic        bus_busy_flag,
  input logic        operation_enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Raw line conditions; sync delay is covered by the ranges below
  sequence s_start;
    scl_in && $fell(sda_in) && operation_enable;
  endsequence
  sequence s_stop;
    scl_in && $rose(sda_in) && operation_enable;
  endsequence
  chk_ready_wait: assert property (psel && $rose(penable) |=> pready) else $error("late ready");
  chk_ready_pulse: assert property (pready |=> !pready) else $error("long ready");
  chk_ready_cause: assert property (pready |-> psel && penable) else $error("stray ready");
  chk_map_err: assert property (pready && paddr > 12'h008 |-> pslverr) else $error("no error");
  chk_rsvd_zero: assert property (pready && paddr == 12'h000 |-> prdata[31:8] == 0 && prdata[5:2] == 0)
    else $error("reserved set");
  chk_go_pulse: assert property (start_go |=> !start_go) else $error("long go");
  chk_go_state: assert property (start_go |-> operation_enable && !bus_busy_flag) else $error("bad go");
  chk_busy_start: assert property (s_start |-> ##[1:8] bus_busy_flag) else $error("busy unset");
  chk_busy_stop: assert property (s_stop |-> ##[1:8] !bus_busy_flag) else $error("busy held");
  chk_busy_off: assert property ($fell(operation_enable) |-> ##[0:1] !bus_busy_flag) else $error("busy on");
endmodule
bind i2c_bus_flag_register i2c_flag_checker u_chk (.clk, .sys_rst, .ce, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pstrb, .prdata, .pready, .pslverr, .scl_in, .sda_in, .start_go, .bus_busy_flag, .operation_enable);

// >>> i2c_bus_peer.sv
// Peer device on the shared bus making start and stop conditions
`timescale 1ns/1ps
module i2c_bus_peer (
  output logic scl,
  output logic sda
);
  // Pulled-up lines rest high; clock stands still between frames
  initial begin
    scl = 1;
    sda = 1;
  end
  // Start: data falls while clock high, then clock held low; the first delay
  // keeps every line change off the system clock edges
  task start_c;
    #20 sda = 0;
    #400 scl = 0;
    #400;
  endtask
  // Stop: clock low for half an 800 ns period, data moves only while clock low,
  // then rises while clock high
  task stop_c;
    #20 scl = 0;
    #200 sda = 0;
    #200 scl = 1;
    #400 sda = 1;
    #400;
  endtask
endmodule

// >>> tb.sv
// Self-checking bench for the bus flag register
`timescale 1ns/1ps
module tb;
  logic        clk = 0;
  logic        sys_rst = 1;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0]  pstrb = 4'hf;
  logic [31:0] seed = 32'h0000_ed7c;
  logic [31:0] prdata;
  logic        pready, pslverr, start_go, bus_busy_flag, operation_enable, scl, sda;
  logic [32:0] expq[$];
  int          fail_count = 0;
  int          check_count = 0;
  int          go_count = 0;
  always #50 clk = ~clk;
  i2c_bus_flag_register u_dut (.clk, .sys_rst, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .scl_in(scl), .sda_in(sda), .start_go, .bus_busy_flag,
    .operation_enable);
  i2c_bus_peer u_peer (.scl(scl), .sda(sda));
  task conclude;
    if (fail_count == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [32:0] got, input logic [32:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  // Master holds the request until ready is seen; bounded wait
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    // pready is taken as the design saw it at each rising edge
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1 && n < 20);
    if (pready !== 1) begin
      fail_count++;
      conclude();
    end else begin
      psel <= 0;
      penable <= 0;
    end
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    apb(1, a, {24'h00_0000, d});
  endtask
  task rd(input logic [11:0] a, input logic [7:0] e, input logic err = 0);
    expq.push_back({err, 24'h00_0000, e});
    apb(0, a, 32'h0000_0000);
  endtask
  // Read results taken in the ready cycle; start_go pulses counted
  always @(posedge clk) begin
    if (pready && psel && !pwrite && expq.size() > 0) chk({pslverr, prdata}, expq.pop_front());
    if (start_go) go_count++;
  end
  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 0;
    rd(12'h000, 8'h00);
    rd(12'h00c, 8'h00, 1);
    seed = xs(seed);
    wr(12'h000, seed[7:0]);
    rd(12'h000, {6'h00, seed[1:0]});
    apb(1, 12'h008, 32'h0000_0002);
    rd(12'h000, {7'h00, seed[0]});
    pstrb <= 4'he;
    wr(12'h000, 8'h02);
    pstrb <= 4'hf;
    rd(12'h000, {7'h00, seed[0]});
    wr(12'h000, 8'h02);
    wr(12'h004, 8'h01);
    rd(12'h000, 8'h02);
    chk(operation_enable, 1);
    chk(bus_busy_flag, 0);
    wr(12'h000, 8'h01);
    rd(12'h000, 8'h02);
    wr(12'h004, 8'h03);
    rd(12'h000, 8'h02);
    chk(go_count, 1);
    wr(12'h004, 8'h00);
    wr(12'h000, 8'h01);
    chk(operation_enable, 0);
    wr(12'h004, 8'h01);
    rd(12'h000, 8'h41);
    chk(bus_busy_flag, 1);
    wr(12'h004, 8'h03);
    rd(12'h000, 8'hc1);
    chk(go_count, 1);
    u_peer.stop_c();
    rd(12'h000, 8'h81);
    chk(bus_busy_flag, 0);
    wr(12'h004, 8'h03);
    rd(12'h000, 8'h01);
    chk(go_count, 2);
    u_peer.start_c();
    rd(12'h000, 8'h41);
    chk(bus_busy_flag, 1);
    wr(12'h004, 8'h00);
    rd(12'h000, 8'h01);
    chk(bus_busy_flag, 0);
    conclude();
  end
endmodule
